// ===== logic/csm_otp_store.sv
// Shared constants and types, plus the one-time-programmable configuration store
package csm_pkg;
    // Clock rate and derived timing counts
    localparam int CLK_FREQ_MHZ = 100;
    localparam int APPLY_TIME_US = 1000;
    localparam int APPLY_CYCLES = APPLY_TIME_US * CLK_FREQ_MHZ;
    localparam int SWITCH_TIME_NS = 160;
    localparam int SWITCH_CYCLES = (SWITCH_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;
    localparam int APPLY_CNT_W = 17;
    localparam int SWITCH_CNT_W = 8;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_CFG0 = 8'h00;
    localparam logic [7:0] IDX_CFG13 = 8'h13;
    localparam logic [7:0] IDX_STATUS = 8'h20;
    localparam logic [7:0] IDX_OTP_WR = 8'h21;
    localparam logic [7:0] IDX_RELOAD = 8'h22;
    localparam logic [11:0] ADDR_CFG0 = {2'b00, IDX_CFG0, 2'b00};
    localparam logic [11:0] ADDR_CFG13 = {2'b00, IDX_CFG13, 2'b00};
    localparam logic [11:0] ADDR_STATUS = {2'b00, IDX_STATUS, 2'b00};
    localparam logic [11:0] ADDR_OTP_WR = {2'b00, IDX_OTP_WR, 2'b00};
    localparam logic [11:0] ADDR_RELOAD = {2'b00, IDX_RELOAD, 2'b00};
    // Field positions inside configuration bytes
    localparam int DEF_BIT_POS = 7;
    localparam int PRIM_BIT_POS = 1;
    localparam int SM_HI_POS = 7;
    // Field positions of the store-write and reload registers
    localparam int OTP_BANK_LSB = 16;
    localparam int OTP_BANK_MSB = 18;
    localparam int RELOAD_BANK_MSB = 2;
    // Field positions of the status register
    localparam int ST_STRAP_POS = 0;
    localparam int ST_MGMT_POS = 1;
    localparam int ST_BUSY_POS = 2;
    localparam int ST_REFSEL_POS = 3;
    localparam int ST_HOLD_POS = 4;
    localparam int ST_BANK_LSB = 8;
    localparam int ST_BURN_LSB = 16;
    // Store geometry
    localparam int NUM_BANKS = 5;
    localparam logic [2:0] BANK_CFG0 = 3'h0;
    localparam logic [2:0] BANK_DEFAULTS = 3'h4;
    // Reset and factory values
    localparam logic [15:0] CFG_RST = 16'h0000;
    localparam logic [15:0] FACTORY_CFG = 16'h0000;
    localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

    // One configuration: the two serial-visible register bytes
    typedef struct packed {
        logic [7:0] reg13;
        logic [7:0] reg0;
    } csm_cfg_t;

    // Write request into the store
    typedef struct packed {
        logic valid;
        logic [2:0] bank;
        csm_cfg_t data;
    } csm_otp_wr_t;

    // Sequencer states
    typedef enum logic [3:0] {
        ST_SAMPLE = 4'b0001,
        ST_LOAD = 4'b0010,
        ST_APPLY = 4'b0100,
        ST_READY = 4'b1000
    } csm_state_t;
endpackage

`timescale 1ns/1ps

// Stored configurations, each bank writable once between resets
module csm_otp_store
    import csm_pkg::*;
(
    input wire logic ref_clk,
    input wire logic srst,
    input csm_otp_wr_t wr,
    input wire logic [2:0] rd_bank,
    output csm_cfg_t rd_cfg,
    output logic [NUM_BANKS-1:0] burned,
    output logic wr_refused
);
    // Bank contents
    csm_cfg_t mem [NUM_BANKS];
    // Per-bank write hit
    logic [NUM_BANKS-1:0] hit;

    // One cell per bank; a burned bank is frozen
    genvar gi;
    generate
        for (gi = 0; gi < NUM_BANKS; gi++) begin : g_bank
            assign hit[gi] = wr.valid && (wr.bank == 3'(gi));
            always_ff @(posedge ref_clk) begin
                if (srst) begin
                    mem[gi] <= FACTORY_CFG;
                    burned[gi] <= 1'b0;
                end else if (hit[gi] && !burned[gi]) begin
                    mem[gi] <= wr.data;
                    burned[gi] <= 1'b1;
                end
            end
        end
    endgenerate

    // Out-of-range or already burned bank refuses the write
    assign wr_refused = wr.valid &&
        ((wr.bank >= NUM_BANKS[2:0]) || ((hit & burned) != '0));
    // Unpopulated bank numbers read as zero
    assign rd_cfg = (rd_bank < NUM_BANKS[2:0]) ? mem[rd_bank] : CFG_RST;
endmodule

// ===== logic/csm_top.sv
// Strap sampling, configuration selection and reference input select
`timescale 1ns/1ps

module csm_top
    import csm_pkg::*;
#(
    parameter int APPLY_CYC = APPLY_CYCLES,
    parameter int SWITCH_CYC = SWITCH_CYCLES
)
(
    input wire logic ref_clk,
    input wire logic srst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Strap pin, later the reference clock output
    input wire logic strap_ref_out_pin_in,
    output logic strap_ref_out_pin_out,
    output logic strap_ref_out_pin_oe,
    // Reference clock to be sent out on the strap pin
    input wire logic ref_out_src,
    // Shared pin 8: select high or serial data
    input wire logic shared_hi_in,
    output logic shared_hi_out,
    output logic shared_hi_oe,
    // Shared pin 9: select low or serial clock
    input wire logic shared_lo_in,
    // Serial engine asks to pull the data line low
    input wire logic mgmt_sda_pull_low,
    // Serial lines forwarded to the serial engine
    output logic mgmt_enable,
    output logic mgmt_sda,
    output logic mgmt_scl,
    // Manual reference select pin
    input wire logic ref_input_select_pin,
    // Chosen reference and break-before-make hold
    output logic ref_sel_diff,
    output logic ref_mux_hold,
    // Active configuration and load busy
    output csm_cfg_t active_cfg,
    output logic cfg_busy
);
    // Sequencer state
    csm_state_t state_reg, state_next;
    // Strap capture
    logic strap_reg;
    logic strap_valid_reg;
    // Selected bank and its latched select pins
    logic [2:0] bank_reg, bank_next;
    logic [1:0] sel_seen_reg;
    // Active configuration
    csm_cfg_t cfg_reg;
    // Apply timer
    logic [APPLY_CNT_W-1:0] apply_cnt_reg;
    // Reference switch
    logic ref_sel_reg;
    logic hold_reg;
    logic [SWITCH_CNT_W-1:0] sw_cnt_reg;
    // APB answer
    logic pready_reg;
    logic pslverr_reg;
    logic [31:0] prdata_reg;
    // Pin drive registers
    logic pin_out_reg;
    logic hi_oe_reg;
    logic mgmt_en_reg;
    logic sda_reg;
    logic scl_reg;
    // Store interface
    csm_otp_wr_t otp_wr;
    csm_cfg_t otp_rd;
    logic [NUM_BANKS-1:0] otp_burned;
    logic otp_refused;

    // Mode flags from the held strap
    wire mgmt_mode = strap_valid_reg && !strap_reg;
    wire hw_mode = strap_valid_reg && strap_reg;
    // Select pins as a bank number; floating pins arrive as low
    wire [1:0] sel_pins = {shared_hi_in, shared_lo_in};
    // Serial defaults apply only with the default bit set and strap low
    wire def_bit = otp_rd.reg0[DEF_BIT_POS];

    // APB phase decode
    wire apb_setup_ok = psel && penable && !pready_reg;
    wire apb_done = psel && penable && pready_reg;
    wire apb_wr = apb_done && pwrite;
    wire hit_cfg0 = (paddr == ADDR_CFG0);
    wire hit_cfg13 = (paddr == ADDR_CFG13);
    wire hit_status = (paddr == ADDR_STATUS);
    wire hit_otp = (paddr == ADDR_OTP_WR);
    wire hit_reload = (paddr == ADDR_RELOAD);
    wire hit_any = hit_cfg0 || hit_cfg13 || hit_status || hit_otp ||
        hit_reload;
    // Configuration writes and reloads are accepted only once loaded and in serial mode; store writes are not gated
    wire prog_ok = (state_reg == ST_READY) && mgmt_mode;
    wire cfg_wr_ok = prog_ok && (hit_cfg0 || hit_cfg13);
    wire reload_ok = prog_ok && hit_reload;
    wire otp_bank_ok = pwdata[OTP_BANK_MSB:OTP_BANK_LSB] < NUM_BANKS[2:0];
    // Error answer decided at the wait cycle
    wire err_wr = pwrite && ((hit_cfg0 || hit_cfg13) && !prog_ok ||
        hit_reload && !prog_ok || hit_status ||
        hit_otp && (!otp_bank_ok ||
        otp_burned[pwdata[OTP_BANK_MSB:OTP_BANK_LSB]]));
    wire err_rd = !pwrite && (hit_otp || hit_reload);
    wire apb_err = !hit_any || err_wr || err_rd;
    // Write strobes at the completing edge
    wire wr_cfg0 = apb_wr && hit_cfg0 && cfg_wr_ok;
    wire wr_cfg13 = apb_wr && hit_cfg13 && cfg_wr_ok;
    wire wr_reload = apb_wr && reload_ok;

    // Read data mux
    wire [31:0] status_word = {
        {(16 - NUM_BANKS){1'b0}}, otp_burned,
        5'h00, bank_reg,
        3'h0, hold_reg, ref_sel_reg, cfg_busy, mgmt_mode, strap_reg};
    wire [31:0] rd_mux = hit_cfg0 ? {24'h00_0000, cfg_reg.reg0} :
        hit_cfg13 ? {24'h00_0000, cfg_reg.reg13} :
        hit_status ? status_word : RDATA_ZERO;

    // Store write request from the store-write register
    assign otp_wr.valid = apb_wr && hit_otp;
    assign otp_wr.bank = pwdata[OTP_BANK_MSB:OTP_BANK_LSB];
    assign otp_wr.data = pwdata[15:0];

    // Store instance; read port follows the held bank, so no loop
    csm_otp_store u_store (
        .ref_clk(ref_clk),
        .srst(srst),
        .wr(otp_wr),
        .rd_bank(bank_reg),
        .rd_cfg(otp_rd),
        .burned(otp_burned),
        .wr_refused(otp_refused)
    );

    // Live select pins differ from the loaded ones
    wire sel_moved = hw_mode && (sel_pins != sel_seen_reg) &&
        !cfg_reg.reg0[DEF_BIT_POS];
    // Apply timer expiry
    wire apply_done = (apply_cnt_reg == '0);

    // Next state and bank choice
    always_comb begin
        state_next = state_reg;
        bank_next = bank_reg;
        case (state_reg)
            // First edge after reset: strap is caught this cycle
            ST_SAMPLE: begin
                state_next = ST_LOAD;
                bank_next = strap_ref_out_pin_in ? {1'b0, sel_pins} :
                    BANK_CFG0;
            end
            // Copy one bank; serial defaults take one more load cycle
            ST_LOAD: begin
                state_next = ST_APPLY;
                if (mgmt_mode && bank_reg == BANK_CFG0 && def_bit &&
                        !sel_seen_reg[0]) begin
                    state_next = ST_LOAD;
                    bank_next = BANK_DEFAULTS;
                end
            end
            // Let the new configuration settle
            ST_APPLY: begin
                if (apply_done) begin
                    state_next = ST_READY;
                end
            end
            // Watch for pin changes or serial reload requests
            ST_READY: begin
                if (sel_moved) begin
                    state_next = ST_LOAD;
                    bank_next = {1'b0, sel_pins};
                end else if (wr_reload) begin
                    state_next = ST_LOAD;
                    bank_next = pwdata[RELOAD_BANK_MSB:0];
                end
            end
            default: begin
                state_next = ST_SAMPLE;
                bank_next = BANK_CFG0;
            end
        endcase
    end

    // Sequencer registers
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state_reg <= ST_SAMPLE;
            bank_reg <= BANK_CFG0;
        end else begin
            state_reg <= state_next;
            bank_reg <= bank_next;
        end
    end

    // Strap capture: once, at the first edge after release
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            strap_reg <= 1'b0;
            strap_valid_reg <= 1'b0;
        end else if (state_reg == ST_SAMPLE && !strap_valid_reg) begin
            strap_reg <= strap_ref_out_pin_in;
            strap_valid_reg <= 1'b1;
        end
    end

    // Remember the pins that chose the current bank
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            sel_seen_reg <= 2'b00;
        end else if (state_reg == ST_SAMPLE) begin
            sel_seen_reg <= strap_ref_out_pin_in ? sel_pins : 2'b00;
        end else if (state_reg == ST_READY && sel_moved) begin
            sel_seen_reg <= sel_pins;
        end
    end

    // Active configuration: loaded from the store or written serially
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            cfg_reg <= CFG_RST;
        end else if (state_reg == ST_LOAD) begin
            cfg_reg <= otp_rd;
        end else if (wr_cfg0) begin
            cfg_reg.reg0 <= pwdata[7:0];
        end else if (wr_cfg13) begin
            cfg_reg.reg13 <= pwdata[7:0];
        end
    end

    // Apply timer: reloaded on every load, counts down while applying
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            apply_cnt_reg <= '0;
        end else if (state_reg == ST_LOAD) begin
            apply_cnt_reg <= APPLY_CNT_W'(APPLY_CYC - 1);
        end else if (state_reg == ST_APPLY && !apply_done) begin
            apply_cnt_reg <= apply_cnt_reg - 1'b1;
        end
    end

    // Reference target: polarity bit xor pin, manual mode only
    wire manual_mode = !cfg_reg.reg13[SM_HI_POS];
    wire ref_target = cfg_reg.reg13[PRIM_BIT_POS] ^
        ref_input_select_pin;
    wire ref_want = manual_mode && (ref_target != ref_sel_reg) &&
        (state_reg == ST_READY);
    wire sw_done = (sw_cnt_reg == '0);

    // Break-before-make switch: hold the mux, then flip and release at the same edge
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ref_sel_reg <= 1'b0;
            hold_reg <= 1'b0;
            sw_cnt_reg <= '0;
        end else if (!hold_reg) begin
            if (ref_want) begin
                hold_reg <= 1'b1;
                sw_cnt_reg <= SWITCH_CNT_W'(SWITCH_CYC - 1);
            end
        end else if (!sw_done) begin
            sw_cnt_reg <= sw_cnt_reg - 1'b1;
        end else begin
            // Flip only if the target still differs at the end
            if (ref_want) begin
                ref_sel_reg <= ref_target;
            end
            hold_reg <= 1'b0;
        end
    end

    // APB answer: one wait cycle, data and error with pready
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= RDATA_ZERO;
        end else if (apb_setup_ok) begin
            pready_reg <= 1'b1;
            pslverr_reg <= apb_err;
            prdata_reg <= apb_err ? RDATA_ZERO : rd_mux;
        end else begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= RDATA_ZERO;
        end
    end

    // Pin roles: strap pin turns to output, shared pins follow the mode
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pin_out_reg <= 1'b0;
            hi_oe_reg <= 1'b0;
            mgmt_en_reg <= 1'b0;
            sda_reg <= 1'b1;
            scl_reg <= 1'b1;
        end else begin
            pin_out_reg <= strap_valid_reg && ref_out_src;
            hi_oe_reg <= mgmt_mode && mgmt_sda_pull_low;
            mgmt_en_reg <= mgmt_mode;
            sda_reg <= mgmt_mode ? shared_hi_in : 1'b1;
            scl_reg <= mgmt_mode ? shared_lo_in : 1'b1;
        end
    end

    // Output enable of the strap pin rises once the strap is held
    logic pin_oe_reg;
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pin_oe_reg <= 1'b0;
        end else begin
            pin_oe_reg <= strap_valid_reg;
        end
    end

    // Busy flag as a register
    logic busy_reg;
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            busy_reg <= 1'b1;
        end else begin
            busy_reg <= (state_next != ST_READY);
        end
    end

    // Outputs straight from registers, except shared_hi_out tied low
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign strap_ref_out_pin_out = pin_out_reg;
    assign strap_ref_out_pin_oe = pin_oe_reg;
    assign shared_hi_out = 1'b0;
    assign shared_hi_oe = hi_oe_reg;
    assign mgmt_enable = mgmt_en_reg;
    assign mgmt_sda = sda_reg;
    assign mgmt_scl = scl_reg;
    assign ref_sel_diff = ref_sel_reg;
    assign ref_mux_hold = hold_reg;
    assign active_cfg = cfg_reg;
    assign cfg_busy = busy_reg;
endmodule

// ===== test/csm_asserts.sv
// Concurrent checks on the strap, select and reference ports
`timescale 1ns/1ps

module csm_asserts
    import csm_pkg::*;
#(
    parameter int APPLY_CYC = APPLY_CYCLES,
    parameter int SWITCH_CYC = SWITCH_CYCLES
)
(
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic strap_ref_out_pin_out,
    input wire logic strap_ref_out_pin_oe,
    input wire logic ref_out_src,
    input wire logic shared_hi_in,
    input wire logic shared_hi_out,
    input wire logic shared_hi_oe,
    input wire logic shared_lo_in,
    input wire logic mgmt_enable,
    input wire logic mgmt_scl,
    input wire logic ref_sel_diff,
    input wire logic ref_mux_hold,
    input csm_cfg_t active_cfg,
    input wire logic cfg_busy
);
    int hold_cnt_reg; // Cycles the reference hold has stood
    int busy_cnt_reg; // Cycles the load busy has stood

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    // Count how long hold and busy stay high
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            hold_cnt_reg <= 0;
            busy_cnt_reg <= 0;
        end else begin
            hold_cnt_reg <= ref_mux_hold ? hold_cnt_reg + 1 : 0;
            busy_cnt_reg <= cfg_busy ? busy_cnt_reg + 1 : 0;
        end
    end

    AST_STRAP_OE_HOLD: assert property (
        strap_ref_out_pin_oe |=> strap_ref_out_pin_oe)
        else $error("strap pin drive dropped");
    AST_REF_OUT_COPY: assert property (
        strap_ref_out_pin_oe && $past(strap_ref_out_pin_oe)
        |-> strap_ref_out_pin_out == $past(ref_out_src))
        else $error("reference output not a copy of its source");
    AST_MODE_FROZEN: assert property (
        strap_ref_out_pin_oe && $past(strap_ref_out_pin_oe)
        |-> $stable(mgmt_enable))
        else $error("pin mode changed after strap was held");
    AST_OD_ONLY_SERIAL: assert property (
        shared_hi_oe |-> mgmt_enable && !shared_hi_out)
        else $error("data line pulled outside serial mode");
    AST_SCL_FOLLOW: assert property (
        mgmt_enable && $past(mgmt_enable)
        |-> mgmt_scl == $past(shared_lo_in))
        else $error("serial clock not forwarded");
    AST_SWITCH_AT_RELEASE: assert property (
        $changed(ref_sel_diff) |-> $fell(ref_mux_hold))
        else $error("reference changed outside the hold release");
    AST_HOLD_SPAN: assert property (
        $fell(ref_mux_hold) |-> hold_cnt_reg == SWITCH_CYC)
        else $error("hold window has wrong length");
    AST_SEL_RELOAD: assert property (
        strap_ref_out_pin_oe && $past(strap_ref_out_pin_oe) && !mgmt_enable
        && !cfg_busy && !active_cfg.reg0[DEF_BIT_POS]
        && $changed({shared_hi_in, shared_lo_in}) |-> ##[1:2] cfg_busy)
        else $error("select change did not start a reload");
    AST_BUSY_SPAN: assert property (
        $fell(cfg_busy) |-> busy_cnt_reg >= APPLY_CYC)
        else $error("load finished too early");
    AST_APB_ONE_WAIT: assert property (
        psel && penable && !pready |=> pready)
        else $error("bus answer not after one wait state");

    // Main scenarios reached
    cover property ($fell(ref_mux_hold));
    cover property ($rose(shared_hi_oe));
    cover property ($fell(cfg_busy) && !mgmt_enable);
endmodule

bind csm_top csm_asserts #(.APPLY_CYC(APPLY_CYC), .SWITCH_CYC(SWITCH_CYC))
    csm_asserts_i (.ref_clk(ref_clk), .srst(srst), .psel(psel),
    .penable(penable), .pready(pready),
    .strap_ref_out_pin_out(strap_ref_out_pin_out),
    .strap_ref_out_pin_oe(strap_ref_out_pin_oe), .ref_out_src(ref_out_src),
    .shared_hi_in(shared_hi_in), .shared_hi_out(shared_hi_out),
    .shared_hi_oe(shared_hi_oe), .shared_lo_in(shared_lo_in),
    .mgmt_enable(mgmt_enable), .mgmt_scl(mgmt_scl),
    .ref_sel_diff(ref_sel_diff), .ref_mux_hold(ref_mux_hold),
    .active_cfg(active_cfg), .cfg_busy(cfg_busy));

// ===== test/csm_far_model.sv
// Board straps, select drivers and serial line levels seen by the block
`timescale 1ns/1ps

module csm_far_model (
    input wire logic strap_lvl,
    input wire logic sel_hi,
    input wire logic sel_lo,
    input wire logic scl_lvl,
    input wire logic sda_low,
    input wire logic pin_out,
    input wire logic pin_oe,
    input wire logic hi_oe,
    output logic strap_pin,
    output logic hi_pin,
    output logic lo_pin
);
    // Strap resistor shows until the block drives its clock out
    assign strap_pin = pin_oe ? pin_out : strap_lvl;
    // Data line: open drain with pull-up in serial mode, tie level else
    assign hi_pin = (hi_oe || sda_low) ? 1'b0 : (!strap_lvl || sel_hi);
    // Serial master clock, or the tie level of the low select
    assign lo_pin = strap_lvl ? sel_lo : scl_lvl;
endmodule

// ===== test/csm_top_tb_top.sv
// Self-checking bench for strap, select and reference input logic
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((e) !== (g)) begin \
    fail_count++; $display("wrong value %s expected %0h seen %0h", \
    nm, e, g); end end

module csm_top_tb_top
    import csm_pkg::*;
;
    localparam int APPLY = 20; // Shortened load time
    localparam int SW = 2; // Shortened hold window
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic ref_out_src = 1'b0, sda_pull = 1'b0, pin = 1'b0;
    logic strap_lvl = 1'b1, sel_hi = 1'b0, sel_lo = 1'b0, scl_lvl = 1'b1;
    logic [31:0] prdata;
    logic pready, pslverr, pin_out, pin_oe, hi_out, hi_oe;
    logic mgmt_enable, mgmt_sda, mgmt_scl, ref_sel_diff, ref_mux_hold;
    logic cfg_busy, strap_pin, hi_pin, lo_pin, er, p;
    csm_cfg_t active_cfg;
    logic [31:0] rd;
    int n, b, i, fail_count, check_count;

    csm_top #(.APPLY_CYC(APPLY), .SWITCH_CYC(SW)) csm_top_i (
        .ref_clk(ref_clk), .srst(srst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .strap_ref_out_pin_in(strap_pin), .strap_ref_out_pin_out(pin_out),
        .strap_ref_out_pin_oe(pin_oe), .ref_out_src(ref_out_src),
        .shared_hi_in(hi_pin), .shared_hi_out(hi_out), .shared_hi_oe(hi_oe),
        .shared_lo_in(lo_pin), .mgmt_sda_pull_low(sda_pull),
        .mgmt_enable(mgmt_enable), .mgmt_sda(mgmt_sda), .mgmt_scl(mgmt_scl),
        .ref_input_select_pin(pin), .ref_sel_diff(ref_sel_diff),
        .ref_mux_hold(ref_mux_hold), .active_cfg(active_cfg),
        .cfg_busy(cfg_busy));

    csm_far_model csm_far_model_i (.strap_lvl(strap_lvl), .sel_hi(sel_hi),
        .sel_lo(sel_lo), .scl_lvl(scl_lvl), .sda_low(1'b0),
        .pin_out(pin_out), .pin_oe(pin_oe), .hi_oe(hi_oe),
        .strap_pin(strap_pin), .hi_pin(hi_pin), .lo_pin(lo_pin));

    // Clock and a toggling reference to send out
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) ref_out_src <= ~ref_out_src;

    // Bank chosen at power-up
    function automatic logic [2:0] exp_bank(logic s, logic h, logic l);
        return s ? {1'b0, h, l} : BANK_CFG0;
    endfunction
    // Differential chosen when primary bit and pin differ
    function automatic logic exp_ref(logic prim, logic sel);
        return prim ^ sel;
    endfunction

    // One APB transfer, waiting for pready
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            fail_count++;
            summarize();
        end
    endtask

    // Wait until the load sequence has finished
    task automatic wait_idle();
        repeat (2) @(posedge ref_clk);
        n = 0;
        while (cfg_busy !== 1'b0 && n < 1000) begin
            @(posedge ref_clk);
            n++;
        end
        if (n >= 1000) begin
            fail_count++;
            summarize();
        end
    endtask

    // Power-on with given strap and select levels
    task automatic rst(input logic s, input logic h, input logic l);
        srst <= 1'b1;
        strap_lvl <= s;
        sel_hi <= h;
        sel_lo <= l;
        repeat (8) @(posedge ref_clk);
        srst <= 1'b0;
        wait_idle();
    endtask

    // Print counts and verdict, then stop
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Cut a hang short
    initial begin
        #100_000;
        fail_count++;
        summarize();
    end

    initial begin
        void'($urandom(32'h4fdc));
        // Every select code with strap high
        for (b = 0; b < 4; b++) begin
            rst(1'b1, b[1], b[0]);
            apb(1'b0, ADDR_STATUS, 32'h0000_0000);
            `CHK("bank", exp_bank(1'b1, b[1], b[0]), rd[ST_BANK_LSB+:3])
            `CHK("strap bit", 1'b1, rd[ST_STRAP_POS])
            `CHK("serial mode", 1'b0, mgmt_enable)
            `CHK("pin drive", 1'b1, pin_oe)
        end
        // Let the scaled power-up settle time pass before touching pins
        repeat (10 * APPLY) @(posedge ref_clk);
        // Change one select only, then leave the block alone
        sel_lo <= 1'b0;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while ((cfg_busy !== 1'b0 || n < 3) && n < 1000);
        if (n >= 1000) begin
            fail_count++;
            summarize();
        end
        `CHK("reload span", 1'b1, n > APPLY)
        apb(1'b0, ADDR_STATUS, 32'h0000_0000);
        `CHK("new bank", exp_bank(1'b1, 1'b1, 1'b0), rd[ST_BANK_LSB+:3])
        // Random manual reference selections
        for (i = 0; i < 8; i++) begin
            pin <= 1'($urandom);
            repeat (SW + 4) @(posedge ref_clk);
            `CHK("ref sel", exp_ref(1'b0, pin), ref_sel_diff)
        end
        apb(1'b1, ADDR_CFG13, 32'h0000_0002);
        `CHK("cfg refused", 1'b1, er)
        apb(1'b0, 12'hFFC, 32'h0000_0000);
        `CHK("unmapped err", 1'b1, er)
        `CHK("unmapped data", RDATA_ZERO, rd)
        // Strap low: serial mode, select pins ignored
        rst(1'b0, 1'($urandom), 1'($urandom));
        `CHK("serial mode", 1'b1, mgmt_enable)
        apb(1'b0, ADDR_STATUS, 32'h0000_0000);
        `CHK("bank", exp_bank(1'b0, 1'b0, 1'b0), rd[ST_BANK_LSB+:3])
        scl_lvl <= 1'b0;
        repeat (4) @(posedge ref_clk);
        `CHK("no reload", 1'b0, cfg_busy)
        `CHK("scl copy", 1'b0, mgmt_scl)
        scl_lvl <= 1'b1;
        sda_pull <= 1'b1;
        repeat (3) @(posedge ref_clk);
        `CHK("sda pull", 1'b1, hi_oe)
        `CHK("sda copy", 1'b0, mgmt_sda)
        sda_pull <= 1'b0;
        apb(1'b1, ADDR_CFG13, 32'h0000_0002);
        apb(1'b0, ADDR_CFG13, 32'h0000_0000);
        `CHK("cfg13", 8'h02, rd[7:0])
        pin <= 1'($urandom);
        repeat (SW + 4) @(posedge ref_clk);
        p = exp_ref(1'b1, pin);
        `CHK("inverted sel", p, ref_sel_diff)
        // Automatic mode: pin no longer steers the reference
        apb(1'b1, ADDR_CFG13, 32'h0000_0082);
        pin <= ~pin;
        repeat (SW + 4) @(posedge ref_clk);
        `CHK("pin ignored", p, ref_sel_diff)
        // Store: one write per bank, then reload it
        apb(1'b1, ADDR_OTP_WR, {13'h0000, 3'h1, 16'h0041});
        `CHK("store write", 1'b0, er)
        apb(1'b1, ADDR_OTP_WR, {13'h0000, 3'h1, 16'h0000});
        `CHK("second write", 1'b1, er)
        apb(1'b1, ADDR_OTP_WR, {13'h0000, 3'h5, 16'h0000});
        `CHK("bad bank", 1'b1, er)
        apb(1'b1, ADDR_RELOAD, 32'h0000_0001);
        wait_idle();
        `CHK("reloaded cfg", 16'h0041, active_cfg)
        // Default bit in bank 0 redirects a serial load to the defaults
        apb(1'b1, ADDR_OTP_WR, {13'h0000, BANK_DEFAULTS, 16'h0203});
        apb(1'b1, ADDR_OTP_WR, {13'h0000, BANK_CFG0, 16'h0080});
        apb(1'b1, ADDR_RELOAD, 32'h0000_0000);
        wait_idle();
        `CHK("defaults cfg", 16'h0203, active_cfg)
        summarize();
    end
endmodule
